// *** pocp_defines.svh ***
// Register offsets, field positions, reset values and timing counts.
`ifndef POCP_DEFINES_SVH
`define POCP_DEFINES_SVH
`define POCP_ADDR_MASTER 8'h00
`define POCP_ADDR_PAR_LO 8'h38
`define POCP_ADDR_PAR_HI 8'h39
`define POCP_ADDR_FAR_LO 8'h3a
`define POCP_ADDR_FAR_HI 8'h3b
`define POCP_ADDR_MODE 8'h3d
`define POCP_ADDR_ERRINS 8'h40
`define POCP_ADDR_PTRCTL 8'h41
`define POCP_ADDR_ARBITRARY_POINTER_VALUE_LO 8'h45
`define POCP_ADDR_ARBITRARY_POINTER_VALUE_HI 8'h46
`define POCP_BIT_BLOCK_MODE 5
`define POCP_BIT_CORRUPT 1
`define POCP_BIT_ALARM 0
`define POCP_BIT_FORCE_TEST_POINTER 6
`define POCP_BIT_SPACING 5
`define POCP_BIT_LOAD 4
`define POCP_BIT_NDFCTL 3
`define POCP_BIT_NEG 2
`define POCP_BIT_POS 1
`define POCP_PTRCTL_MASK 8'h78
`define POCP_ERRINS_MASK 8'h03
`define POCP_MODE_MASK 8'h20
`define POCP_ARBITRARY_POINTER_VALUE_HI_RESET 8'h90
`define POCP_NDF_NORMAL 4'h6
`define POCP_PTR_LIMIT 10'd782
`define POCP_SNAP_DELAY_NS 1000
`define POCP_CLK_PERIOD_NS 50
`define POCP_SNAP_CYCLES (`POCP_SNAP_DELAY_NS / `POCP_CLK_PERIOD_NS)
`define POCP_SPACE_SHORT 3'd2
`define POCP_SPACE_LONG 3'd4
`endif

// *** pocp_pkg.sv ***
// Types shared by the path overhead counter and pointer control block.
package pocp_pkg;
  typedef enum logic [2:0] {
    POCP_STUFF_IDLE = 3'b001,
    POCP_STUFF_WAIT = 3'b010,
    POCP_STUFF_HOLD = 3'b100
  } pocp_stuff_e;
endpackage

// *** pocp_top.sv ***
// Path overhead error counters and transmit pointer control.
//
// Functional notes
// - Snapshot parity count 1 us after trigger.
// - Clear parity counter when snapshot taken.
// - Snapshot far-end count on same trigger.
// - Clear far-end counter when snapshot taken.
// - Snapshots hold count since previous clear.
// - Far-end bytes at 3a/3b, read-only, reset zero.
// - Block mode counts one error per block.
// - Corrupt bit inverts transmitted parity byte.
// - Alarm forces payload and pointer bytes ones.
// - Test force inserts pointer, keeps flag.
// - Spacing bit selects two or four frames.
// - Request bits give one pointer adjustment.
// - Load inserts pointer and stored flag.
// - Load only when pointer in 1..781.
// - Load affects transmit stream only.
// - Flag control selects normal or stored flag.
// - Load set overrides flag control bit.
// - Requests need fixed pointer; self-clear.
//
// Receive side: two 16-bit error counters feed snapshot registers that
// software reads byte by byte. A write to any snapshot byte or to the
// master register starts a short delay, after which both counts are
// copied and the live counters restart from zero.
//
// Transmit side: the outgoing byte stream passes through one register
// stage. Parity corruption, path alarm, pointer load, test pointer and
// flag control act on the byte marked by the frame position inputs.
//
// Pointer adjustments leave as one-cycle strobes to the pointer
// generator, spaced by the stuff spacing bit.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "pocp_defines.svh"
module pocp_top #(
  parameter int SNAP_CYCLES = `POCP_SNAP_CYCLES
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Receive overhead events.
  input wire logic rx_b3_valid,
  input wire logic [7:0] rx_b3_mismatch,
  input wire logic rx_g1_valid,
  input wire logic [3:0] rx_g1_febe,
  // Transmit frame marks and bytes.
  input wire logic fixed_pointer_enable,
  input wire logic tx_frame_start,
  input wire logic tx_is_b3,
  input wire logic tx_is_h1,
  input wire logic tx_is_h2,
  input wire logic tx_is_payload,
  input wire logic [7:0] tx_byte_in,
  output logic [7:0] tx_byte_out,
  // Pointer adjustment strobes to the pointer generator.
  output logic tx_neg_adjust,
  output logic tx_pos_adjust
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Live error counters and the snapshots that software reads.
  logic [15:0] path_parity_error_count_ff;
  logic [15:0] far_block_error_count_ff;
  logic [15:0] par_snap_ff;
  logic [15:0] far_snap_ff;
  // Software control registers.
  logic [7:0] mode_ff;
  logic [7:0] errins_ff;
  logic [7:0] ptrctl_ff;
  logic [9:0] arbitrary_pointer_value_ff;
  logic [7:0] arbitrary_pointer_value_hi_ff;
  // Snapshot delay timer.
  logic [15:0] snap_cnt_ff;
  logic snap_busy_ff;
  logic snap_now;
  logic trigger;
  // Pending stuff requests, frame spacing and request state.
  logic neg_pend_ff;
  logic pos_pend_ff;
  logic [2:0] frame_gap_ff;
  pocp_pkg::pocp_stuff_e stuff_st_ff;
  // Per-cycle counter increments.
  logic [3:0] par_inc;
  logic [3:0] far_inc;
  // Control bits by name.
  logic block_parity_mode;
  logic corrupt_path_parity;
  logic force_path_alarm;
  logic force_test_pointer;
  logic pointer_load;
  logic new_data_flag_control;
  // Transmit modification terms and next values.
  logic load_ok;
  logic [2:0] space_need;
  logic stuff_allowed;
  logic [3:0] flag_val;
  logic [7:0] nxt_tx;
  logic [7:0] nxt_rdata;

  // ----------------------------------------------------------------------
  // Control bit decode
  // ----------------------------------------------------------------------
  // Control bits picked out of the software registers by name.
  assign block_parity_mode = mode_ff[`POCP_BIT_BLOCK_MODE];
  assign corrupt_path_parity = errins_ff[`POCP_BIT_CORRUPT];
  assign force_path_alarm = errins_ff[`POCP_BIT_ALARM];
  assign force_test_pointer = ptrctl_ff[`POCP_BIT_FORCE_TEST_POINTER];
  assign pointer_load = ptrctl_ff[`POCP_BIT_LOAD];
  assign new_data_flag_control = ptrctl_ff[`POCP_BIT_NDFCTL];

  // ----------------------------------------------------------------------
  // Snapshot trigger
  // ----------------------------------------------------------------------
  // A write to any snapshot byte or to the master register arms a snapshot.
  // Reads never arm it; only the write strobe counts.
  assign trigger = reg_wr && (reg_addr == `POCP_ADDR_MASTER ||
    reg_addr == `POCP_ADDR_PAR_LO || reg_addr == `POCP_ADDR_PAR_HI ||
    reg_addr == `POCP_ADDR_FAR_LO || reg_addr == `POCP_ADDR_FAR_HI);

  // ----------------------------------------------------------------------
  // Snapshot delay
  // ----------------------------------------------------------------------
  // Counts about one microsecond; a new trigger restarts the count.
  // A trigger at edge E takes the snapshot at edge E plus SNAP_CYCLES.
  // The wait is counted in clock cycles, so it follows the clock rate.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_cnt_ff <= 16'h0000;
      snap_busy_ff <= 1'b0;
    end else if (trigger) begin
      // A later trigger always restarts the wait from the top.
      snap_cnt_ff <= 16'(SNAP_CYCLES - 1);
      snap_busy_ff <= 1'b1;
    end else if (snap_busy_ff) begin
      if (snap_cnt_ff == 16'h0000) begin
        snap_busy_ff <= 1'b0;
      end else begin
        snap_cnt_ff <= snap_cnt_ff - 16'h0001;
      end
    end
  end

  // The snapshot fires on the last count unless a fresh trigger lands in
  // the same cycle, which restarts the wait instead.
  assign snap_now = snap_busy_ff && (snap_cnt_ff == 16'h0000) && !trigger;

  // ----------------------------------------------------------------------
  // Error counters
  // ----------------------------------------------------------------------
  // Parity increment is the bit count or one per block.
  // In block mode any mismatch in the byte counts as one error.
  always_comb begin
    par_inc = 4'h0;
    if (rx_b3_valid) begin
      if (block_parity_mode) begin
        par_inc = {3'b000, |rx_b3_mismatch};
      end else begin
        for (int i = 0; i < 8; i++) begin
          par_inc = par_inc + {3'b000, rx_b3_mismatch[i]};
        end
      end
    end
    // Far-end errors arrive as a count and are added as they stand.
    far_inc = rx_g1_valid ? rx_g1_febe : 4'h0;
  end

  // The snapshot takes the count including this cycle's event, so none is
  // lost, and the counter restarts from zero.
  // Counters wrap on overflow; the snapshot is then short.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      path_parity_error_count_ff <= 16'h0000;
      par_snap_ff <= 16'h0000;
    end else if (snap_now) begin
      // Copy and clear share one edge, so no event slips between them.
      par_snap_ff <= path_parity_error_count_ff + {12'h000, par_inc};
      path_parity_error_count_ff <= 16'h0000;
    end else begin
      path_parity_error_count_ff <= path_parity_error_count_ff +
        {12'h000, par_inc};
    end
  end

  // Far-end block error counter and its snapshot.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      far_block_error_count_ff <= 16'h0000;
      far_snap_ff <= 16'h0000;
    end else if (snap_now) begin
      far_snap_ff <= far_block_error_count_ff + {12'h000, far_inc};
      far_block_error_count_ff <= 16'h0000;
    end else begin
      far_block_error_count_ff <= far_block_error_count_ff +
        {12'h000, far_inc};
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // Software-written control bits; stuff requests are never stored.
  // The high pointer byte also holds the flag nibble and spare bits.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= 8'h00;
      errins_ff <= 8'h00;
      ptrctl_ff <= 8'h00;
      arbitrary_pointer_value_ff <= 10'h000;
      arbitrary_pointer_value_hi_ff <= `POCP_ARBITRARY_POINTER_VALUE_HI_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `POCP_ADDR_MODE: mode_ff <= reg_wdata & `POCP_MODE_MASK;
        `POCP_ADDR_ERRINS: errins_ff <= reg_wdata & `POCP_ERRINS_MASK;
        `POCP_ADDR_PTRCTL: begin
          // Request bits are masked out, so they always read back zero.
          ptrctl_ff <= reg_wdata & `POCP_PTRCTL_MASK;
        end
        `POCP_ADDR_ARBITRARY_POINTER_VALUE_LO: arbitrary_pointer_value_ff[7:0] <= reg_wdata;
        // Bits 1:0 of the high byte are the top of the pointer.
        `POCP_ADDR_ARBITRARY_POINTER_VALUE_HI: begin
          arbitrary_pointer_value_hi_ff <= reg_wdata;
          arbitrary_pointer_value_ff[9:8] <= reg_wdata[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------------
  // Read mux; unmapped addresses and idle cycles give zero.
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `POCP_ADDR_PAR_LO: nxt_rdata = par_snap_ff[7:0];
        `POCP_ADDR_PAR_HI: nxt_rdata = par_snap_ff[15:8];
        `POCP_ADDR_FAR_LO: nxt_rdata = far_snap_ff[7:0];
        `POCP_ADDR_FAR_HI: nxt_rdata = far_snap_ff[15:8];
        `POCP_ADDR_MODE: nxt_rdata = mode_ff;
        `POCP_ADDR_ERRINS: nxt_rdata = errins_ff;
        `POCP_ADDR_PTRCTL: nxt_rdata = ptrctl_ff;
        `POCP_ADDR_ARBITRARY_POINTER_VALUE_LO: nxt_rdata = arbitrary_pointer_value_ff[7:0];
        `POCP_ADDR_ARBITRARY_POINTER_VALUE_HI: nxt_rdata = arbitrary_pointer_value_hi_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // Read data stand for one cycle after the strobe, then return to zero.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Stuff requests and spacing
  // ----------------------------------------------------------------------
  // Spacing counts frame starts since the last adjustment, saturating.
  assign space_need = ptrctl_ff[`POCP_BIT_SPACING] ?
    `POCP_SPACE_LONG : `POCP_SPACE_SHORT;
  assign stuff_allowed = (frame_gap_ff >= space_need);

  // A write with a request bit set pends one adjustment when fixed
  // pointer mode is enabled; it is issued at a frame start once spacing
  // from the last adjustment is met.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      neg_pend_ff <= 1'b0;
      pos_pend_ff <= 1'b0;
      tx_neg_adjust <= 1'b0;
      tx_pos_adjust <= 1'b0;
      frame_gap_ff <= `POCP_SPACE_LONG;
      stuff_st_ff <= pocp_pkg::POCP_STUFF_IDLE;
    end else begin
      tx_neg_adjust <= 1'b0;
      tx_pos_adjust <= 1'b0;
      if (tx_frame_start && frame_gap_ff < `POCP_SPACE_LONG) begin
        // Saturating at the longest need keeps the count from wrapping.
        frame_gap_ff <= frame_gap_ff + 3'd1;
      end
      unique case (stuff_st_ff)
        pocp_pkg::POCP_STUFF_IDLE: begin
          if (reg_wr && reg_addr == `POCP_ADDR_PTRCTL &&
              fixed_pointer_enable) begin
            // With both bits set the negative request wins.
            neg_pend_ff <= reg_wdata[`POCP_BIT_NEG];
            pos_pend_ff <= reg_wdata[`POCP_BIT_POS] &
              !reg_wdata[`POCP_BIT_NEG];
            if (reg_wdata[`POCP_BIT_NEG] || reg_wdata[`POCP_BIT_POS]) begin
              stuff_st_ff <= pocp_pkg::POCP_STUFF_WAIT;
            end
          end
        end
        pocp_pkg::POCP_STUFF_WAIT: begin
          if (tx_frame_start && stuff_allowed) begin
            tx_neg_adjust <= neg_pend_ff;
            tx_pos_adjust <= pos_pend_ff;
            neg_pend_ff <= 1'b0;
            pos_pend_ff <= 1'b0;
            // The adjusting frame counts as the first of the spacing.
            frame_gap_ff <= 3'd1;
            stuff_st_ff <= pocp_pkg::POCP_STUFF_HOLD;
          end
        end
        pocp_pkg::POCP_STUFF_HOLD: begin
          // One quiet cycle lets the strobe drop before a new request.
          stuff_st_ff <= pocp_pkg::POCP_STUFF_IDLE;
        end
        default: stuff_st_ff <= pocp_pkg::POCP_STUFF_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Transmit byte modification
  // ----------------------------------------------------------------------
  // A zero or out-of-range pointer blocks the load; test force still inserts it.
  assign load_ok = pointer_load && (arbitrary_pointer_value_ff != 10'h000) &&
    (arbitrary_pointer_value_ff < `POCP_PTR_LIMIT);

  // Flag nibble: load uses stored flag and overrides the control bit.
  always_comb begin
    if (load_ok) begin
      flag_val = arbitrary_pointer_value_hi_ff[7:4];
    end else if (new_data_flag_control && !pointer_load) begin
      // Flag control only counts while pointer load is clear.
      flag_val = arbitrary_pointer_value_hi_ff[7:4];
    end else begin
      flag_val = `POCP_NDF_NORMAL;
    end
  end

  // Only the outgoing stream is touched; receive interpretation is not.
  always_comb begin
    nxt_tx = tx_byte_in;
    // The spare bits in H1[3:2] pass through untouched.
    if (tx_is_h1) begin
      nxt_tx[7:4] = flag_val;
      if (load_ok || force_test_pointer) begin
        nxt_tx[1:0] = arbitrary_pointer_value_ff[9:8];
      end
    end else if (tx_is_h2 && (load_ok || force_test_pointer)) begin
      nxt_tx = arbitrary_pointer_value_ff[7:0];
    end else if (tx_is_b3 && corrupt_path_parity) begin
      nxt_tx = ~tx_byte_in;
    end
    // Alarm insertion comes last so it overrides every other change to H1, H2 and payload bytes.
    if (force_path_alarm && (tx_is_payload || tx_is_h1 || tx_is_h2)) begin
      nxt_tx = 8'hff;
    end
  end

  // ----------------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------------
  // Registered transmit byte.
  // One cycle of latency keeps the output straight from a flip-flop.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_byte_out <= 8'h00;
    end else begin
      tx_byte_out <= nxt_tx;
    end
  end

endmodule

// *** pocp_top_sva.sv ***
// Port-level checks for the counter and pointer control block.
`timescale 1ns/1ps
module pocp_top_sva #(
  parameter int SNAP_CYCLES = 20
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port.
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Transmit side.
  input wire logic tx_frame_start,
  input wire logic tx_is_b3,
  input wire logic tx_is_h1,
  input wire logic tx_is_h2,
  input wire logic tx_is_payload,
  input wire logic [7:0] tx_byte_in,
  input wire logic [7:0] tx_byte_out,
  input wire logic tx_neg_adjust,
  input wire logic tx_pos_adjust
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Read data only ever follows a read strobe.
  AST_RDATA_IDLE: assert property (reg_rdata != 8'h00
    |-> $past(reg_rd))
    else $error("read data without a read");
  // Adjustments land the cycle after a frame start.
  AST_NEG_FRAME: assert property (tx_neg_adjust
    |-> $past(tx_frame_start))
    else $error("negative adjust off frame");
  AST_POS_FRAME: assert property (tx_pos_adjust
    |-> $past(tx_frame_start))
    else $error("positive adjust off frame");
  AST_ADJ_EXCL: assert property (!(tx_neg_adjust && tx_pos_adjust))
    else $error("both adjustments at once");
  AST_ADJ_PULSE: assert property ((tx_neg_adjust || tx_pos_adjust)
    |=> !(tx_neg_adjust || tx_pos_adjust))
    else $error("adjustment longer than one cycle");
  // Bytes outside the overhead and payload pass untouched.
  AST_PASS: assert property (!(tx_is_b3 || tx_is_h1 || tx_is_h2
    || tx_is_payload) |=> tx_byte_out == $past(tx_byte_in))
    else $error("plain byte altered");
  AST_PAYLOAD: assert property (tx_is_payload |=> tx_byte_out ==
    $past(tx_byte_in) || tx_byte_out == 8'hff)
    else $error("payload neither kept nor forced");
  AST_B3: assert property (tx_is_b3 |=>
    tx_byte_out == $past(tx_byte_in) || tx_byte_out == ~$past(tx_byte_in))
    else $error("parity byte neither kept nor inverted");
  COV_NEG: cover property (tx_neg_adjust);
  COV_POS: cover property (tx_pos_adjust);
  COV_AIS: cover property (tx_is_payload ##1 tx_byte_out == 8'hff);
endmodule
bind pocp_top pocp_top_sva #(.SNAP_CYCLES(SNAP_CYCLES)) u_sva (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .tx_frame_start(tx_frame_start),
  .tx_is_b3(tx_is_b3), .tx_is_h1(tx_is_h1), .tx_is_h2(tx_is_h2),
  .tx_is_payload(tx_is_payload), .tx_byte_in(tx_byte_in),
  .tx_byte_out(tx_byte_out), .tx_neg_adjust(tx_neg_adjust),
  .tx_pos_adjust(tx_pos_adjust));

// *** test_pocp_top.sv ***
// Self-checking bench for the counter and pointer control block.
`timescale 1ns/1ps
module test_pocp_top;
  localparam int SNAP = 4;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic b3_v = 1'b0;
  logic [7:0] b3_m = 8'h00;
  logic g1_v = 1'b0;
  logic [3:0] g1_f = 4'h0;
  logic fixed_en = 1'b0;
  logic frame = 1'b0;
  logic [3:0] kind = 4'h0;
  logic [7:0] tx_in = 8'h00;
  logic [7:0] tx_out;
  logic neg;
  logic pos;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  int n_frm = 0;
  int last = 0;
  int gap = 0;
  int n_neg = 0;
  int n_pos = 0;
  pocp_top #(.SNAP_CYCLES(SNAP)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_b3_valid(b3_v),
    .rx_b3_mismatch(b3_m), .rx_g1_valid(g1_v), .rx_g1_febe(g1_f),
    .fixed_pointer_enable(fixed_en), .tx_frame_start(frame),
    .tx_is_b3(kind[3]), .tx_is_h1(kind[2]), .tx_is_h2(kind[1]),
    .tx_is_payload(kind[0]), .tx_byte_in(tx_in), .tx_byte_out(tx_out),
    .tx_neg_adjust(neg), .tx_pos_adjust(pos));
  always #25 sys_clk = ~sys_clk;
  // ----------------------------------------
  // Monitor and shared tasks
  // ----------------------------------------
  // Counts cycles, frames and adjustments; cuts a hang short.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
    n_frm += int'(frame === 1'b1);
    n_neg += int'(neg === 1'b1);
    n_pos += int'(pos === 1'b1);
    if (neg === 1'b1 || pos === 1'b1) begin
      gap = n_frm - last;
      last = n_frm;
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(string n, logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Reads in one cycle and compares the data of the next.
  task automatic rc(string n, logic [7:0] a, logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check(n, reg_rdata, e);
  endtask
  task automatic ev(logic [7:0] m, logic [3:0] f);
    @(posedge sys_clk);
    {b3_v, b3_m, g1_v, g1_f} <= {1'b1, m, 1'b1, f};
    @(posedge sys_clk);
    {b3_v, g1_v} <= 2'b00;
  endtask
  task automatic tx(string n, logic [3:0] k, logic [7:0] d, logic [7:0] e);
    @(posedge sys_clk);
    kind <= k;
    tx_in <= d;
    @(posedge sys_clk);
    kind <= 4'h0;
    #1 check(n, tx_out, e);
  endtask
  task automatic frames(int n);
    repeat (n) begin
      @(posedge sys_clk);
      frame <= 1'b1;
      @(posedge sys_clk);
      frame <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask
  // Requests an adjustment and runs frames until it is issued.
  task automatic adj(logic [7:0] req);
    int base;
    base = n_neg + n_pos;
    wr(8'h41, req);
    repeat (8) if (n_neg + n_pos == base) frames(1);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_regs();
    rc("par_lo", 8'h38, 8'h00);
    rc("far_lo", 8'h3a, 8'h00);
    rc("far_hi", 8'h3b, 8'h00);
    rc("flag_ptr", 8'h46, 8'h90);
    wr(8'h3d, 8'hff);
    wr(8'h40, 8'hff);
    wr(8'h41, 8'hff);
    wr(8'h7e, 8'hff);
    rc("mode", 8'h3d, 8'h20);
    rc("errins", 8'h40, 8'h03);
    rc("ptrctl", 8'h41, 8'h78);
    rc("unmapped", 8'h7e, 8'h00);
    wr(8'h3d, 8'h00);
    wr(8'h40, 8'h00);
    wr(8'h41, 8'h00);
    $display("test_regs done");
  endtask
  task automatic test_counts();
    repeat (40) ev(8'hff, 4'h9);
    wr(8'h00, 8'h00);
    rc("early", 8'h38, 8'h00);
    repeat (SNAP) @(posedge sys_clk);
    rc("par_lo", 8'h38, 8'h40);
    rc("par_hi", 8'h39, 8'h01);
    rc("far_lo", 8'h3a, 8'h68);
    rc("far_hi", 8'h3b, 8'h01);
    wr(8'h3a, 8'h55);
    repeat (SNAP) @(posedge sys_clk);
    rc("par_clr", 8'h38, 8'h00);
    rc("far_clr", 8'h3a, 8'h00);
    wr(8'h3d, 8'h20);
    repeat (3) ev(8'h81, 4'h0);
    wr(8'h39, 8'h00);
    repeat (SNAP) @(posedge sys_clk);
    rc("block", 8'h38, 8'h03);
    $display("test_counts done");
  endtask
  task automatic test_tx();
    tx("h1_norm", 4'h4, 8'h0f, 8'h6f);
    wr(8'h40, 8'h02);
    tx("b3_inv", 4'h8, 8'h5a, 8'ha5);
    wr(8'h40, 8'h01);
    tx("pay_ais", 4'h1, 8'h12, 8'hff);
    tx("h2_ais", 4'h2, 8'h12, 8'hff);
    wr(8'h40, 8'h00);
    tx("b3_norm", 4'h8, 8'h5a, 8'h5a);
    wr(8'h45, 8'h34);
    wr(8'h46, 8'h92);
    wr(8'h41, 8'h10);
    tx("h1_load", 4'h4, 8'h0c, 8'h9e);
    tx("h2_load", 4'h2, 8'h00, 8'h34);
    wr(8'h46, 8'h93);
    wr(8'h41, 8'h18);
    tx("h1_ign", 4'h4, 8'h00, 8'h60);
    tx("h2_big", 4'h2, 8'h55, 8'h55);
    wr(8'h46, 8'h91);
    wr(8'h41, 8'h40);
    tx("h1_force", 4'h4, 8'h00, 8'h61);
    wr(8'h41, 8'h08);
    tx("h1_flag", 4'h4, 8'h00, 8'h90);
    wr(8'h41, 8'h00);
    $display("test_tx done");
  endtask
  task automatic test_stuff();
    wr(8'h41, 8'h04);
    frames(6);
    check("no_fixed", 8'(n_neg), 8'h00);
    fixed_en <= 1'b1;
    wr(8'h41, 8'h06);
    rc("self_clr", 8'h41, 8'h00);
    frames(6);
    check("neg_one", 8'(n_neg), 8'h01);
    adj(8'h02);
    adj(8'h02);
    check("gap_two", 8'(gap), 8'h02);
    adj(8'h24);
    check("gap_four", 8'(gap), 8'h04);
    check("pos_two", 8'(n_pos), 8'h02);
    $display("test_stuff done");
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_regs();
    test_counts();
    test_tx();
    test_stuff();
    complete_run();
  end
endmodule
